// [hw/mgr_coil_pulse.sv]
// coil current pulse timer for set and reset polarity pulses
`timescale 1ns/100ps
`include "mgr_params.svh"

module mgr_coil_pulse (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic go_set,
    input  wire logic go_reset,
    output logic      coil_set,
    output logic      coil_reset,
    output logic      done
);

    localparam logic [`MGR_COIL_CNT_W-1:0] LAST = `MGR_COIL_CNT_W'(`MGR_COIL_CYCLES - 1);

    mgr_pkg::mgr_pulse_state_t s;
    mgr_pkg::mgr_pulse_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // pulse runs a fixed count; requests that arrive while the coil is busy are dropped
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (s.active) begin
            if (s.cnt == LAST) begin
                next_s.active     = 1'b0;
                next_s.coil_set   = 1'b0;
                next_s.coil_reset = 1'b0;
                next_s.done       = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end else if (go_set) begin
            next_s.active   = 1'b1;
            next_s.cnt      = '0;
            next_s.coil_set = 1'b1;
        end else if (go_reset) begin
            next_s.active     = 1'b1;
            next_s.cnt        = '0;
            next_s.coil_reset = 1'b1;
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign coil_set   = s.coil_set;
    assign coil_reset = s.coil_reset;
    assign done       = s.done;

    ////////////////////////////////////////////////////////////////////////////////
    // helper: length of the current coil pulse in enabled cycles
    logic [7:0] hi_cnt;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hi_cnt <= 8'h00;
        end else if (clk_en) begin
            hi_cnt <= (next_s.coil_set || next_s.coil_reset) ? hi_cnt + 8'h01 : 8'h00;
        end
    end

    a_coil_width: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && s.active && s.cnt == LAST) |-> (hi_cnt == 8'(`MGR_COIL_CYCLES)))
        else $error("coil pulse length wrong");

    a_coil_exclusive: assert property (@(posedge clock) disable iff (!rst_b)
        !(s.coil_set && s.coil_reset) && (!(s.coil_set || s.coil_reset) || s.active))
        else $error("both coil polarities driven");

endmodule

// [hw/mgr_params.svh]
// constants of the magnetometer readout and measurement control block
`ifndef MGR_PARAMS_SVH
`define MGR_PARAMS_SVH

// register offsets
`define MGR_ADDR_X_HIGH     8'h00
`define MGR_ADDR_X_MID      8'h01
`define MGR_ADDR_Y_HIGH     8'h02
`define MGR_ADDR_Y_MID      8'h03
`define MGR_ADDR_Z_HIGH     8'h04
`define MGR_ADDR_Z_MID      8'h05
`define MGR_ADDR_LOW_BITS   8'h06
`define MGR_ADDR_TEMP       8'h07
`define MGR_ADDR_STATUS     8'h08
`define MGR_ADDR_CTRL       8'h09

// status bit positions
`define MGR_ST_FIELD_DONE   0
`define MGR_ST_TEMP_DONE    1
`define MGR_ST_OTP_DONE     4

// control bit positions
`define MGR_CT_START_FIELD  0
`define MGR_CT_START_TEMP   1
`define MGR_CT_INT_EN       2
`define MGR_CT_SET_PULSE    3
`define MGR_CT_RESET_PULSE  4
`define MGR_CT_AUTO_PULSE   5
`define MGR_CT_OTP_RELOAD   6

// widths and reset values
`define MGR_AXIS_W          18
`define MGR_TEMP_W          8
`define MGR_BYTE_ZERO       8'h00
`define MGR_LOW_PAD         2'h0

// coil pulse timing, least time so round up
`define MGR_CLOCK_NS        10
`define MGR_COIL_PULSE_NS   500
`define MGR_COIL_CYCLES     ((`MGR_COIL_PULSE_NS + `MGR_CLOCK_NS - 1) / `MGR_CLOCK_NS)
`define MGR_COIL_CNT_W      6

`endif

// [hw/mgr_pkg.sv]
// types of the magnetometer readout and measurement control block
`include "mgr_params.svh"

package mgr_pkg;

    // measurement sequencer states
    typedef enum logic [2:0] {
        MGR_IDLE,
        MGR_COIL_MAN,
        MGR_COIL_AUTO,
        MGR_FIELD,
        MGR_TEMP,
        MGR_OTP
    } mgr_seq_t;

    // whole state of the register and sequencer module
    typedef struct packed {
        mgr_seq_t                  seq;
        logic [`MGR_AXIS_W-1:0]    x;
        logic [`MGR_AXIS_W-1:0]    y;
        logic [`MGR_AXIS_W-1:0]    z;
        logic [`MGR_TEMP_W-1:0]    temp;
        logic                      field_done;
        logic                      temp_done;
        logic                      otp_done;
        logic                      field_pend;
        logic                      temp_pend;
        logic                      start_field;
        logic                      start_temp;
        logic                      int_en;
        logic                      set_req;
        logic                      reset_req;
        logic                      auto_en;
        logic                      otp_req;
        logic                      fired_set;
        logic                      go_set;
        logic                      go_reset;
        logic [7:0]                rdata;
        logic                      rvalid;
        logic                      int_out;
        logic                      int_oe;
        logic                      afe_field_start;
        logic                      afe_temp_start;
        logic                      otp_start;
    } mgr_state_t;

    // whole state of the coil pulse timer
    typedef struct packed {
        logic [`MGR_COIL_CNT_W-1:0] cnt;
        logic                       active;
        logic                       coil_set;
        logic                       coil_reset;
        logic                       done;
    } mgr_pulse_state_t;

endpackage

// [hw/mgr_top.sv]
// register file and measurement sequencer of the magnetometer readout
`timescale 1ns/100ps
`include "mgr_params.svh"
// Notes on behaviour
// - x result split high, mid, low bits
// - y result split high, mid, low bits
// - z result split high, mid, low bits
// - temperature is unsigned eight-bit code
// - field done clears on command, sets at end
// - temp done clears on command, sets at end
// - writing one to done clears interrupt
// - status bit four set after successful trim load
// - field start bit self-clears at end
// - temp start bit self-clears at end
// - enabled interrupt fires on conversion end
// - set pulse drives coil 500 ns
// - reset pulse drives coil 500 ns
// - auto polarity pulse before each field conversion
// - trim reload bit clears when refreshed
// - interrupt active high, undriven until enabled
// - slave only, answers host accesses

module mgr_top (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    output logic                        afe_field_start,
    input  wire logic                   afe_field_done,
    input  wire logic [`MGR_AXIS_W-1:0] afe_x,
    input  wire logic [`MGR_AXIS_W-1:0] afe_y,
    input  wire logic [`MGR_AXIS_W-1:0] afe_z,
    output logic                        afe_temp_start,
    input  wire logic                   afe_temp_done,
    input  wire logic [`MGR_TEMP_W-1:0] afe_temp,
    output logic                        otp_start,
    input  wire logic                   otp_done,
    input  wire logic                   otp_ok,
    output logic                        coil_set,
    output logic                        coil_reset,
    output logic                        int_out,
    output logic                        int_oe
);

    mgr_pkg::mgr_state_t s;
    mgr_pkg::mgr_state_t next_s;
    logic                pulse_done;

    ////////////////////////////////////////////////////////////////////////////////
    // coil pulse timer
    mgr_coil_pulse u_pulse (
        .clock      (clock),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .go_set     (s.go_set),
        .go_reset   (s.go_reset),
        .coil_set   (coil_set),
        .coil_reset (coil_reset),
        .done       (pulse_done)
    );

    // conversion end events, used only by the checks below, and status and control write strobes
    logic field_end;
    logic temp_end;
    logic wr_status;
    logic wr_ctrl;
    assign field_end = (s.seq == mgr_pkg::MGR_FIELD) && afe_field_done;
    assign temp_end  = (s.seq == mgr_pkg::MGR_TEMP) && afe_temp_done;
    assign wr_status = reg_write && (reg_addr == `MGR_ADDR_STATUS);
    assign wr_ctrl   = reg_write && (reg_addr == `MGR_ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////////////
    // next state: register writes, then sequencer; hardware sets come last so they win
    always_comb begin
        next_s                 = s;
        next_s.go_set          = 1'b0;
        next_s.go_reset        = 1'b0;
        next_s.afe_field_start = 1'b0;
        next_s.afe_temp_start  = 1'b0;
        next_s.otp_start       = 1'b0;
        next_s.rvalid          = 1'b0;

        // status write: a one clears only the pending interrupt, not the done flag
        if (wr_status) begin
            if (reg_wdata[`MGR_ST_FIELD_DONE]) begin
                next_s.field_pend = 1'b0;
            end
            if (reg_wdata[`MGR_ST_TEMP_DONE]) begin
                next_s.temp_pend = 1'b0;
            end
        end

        // control write: action bits only set, configuration bits follow the write
        if (wr_ctrl) begin
            next_s.int_en  = reg_wdata[`MGR_CT_INT_EN];
            next_s.auto_en = reg_wdata[`MGR_CT_AUTO_PULSE];
            if (reg_wdata[`MGR_CT_START_FIELD]) begin
                next_s.start_field = 1'b1;
                next_s.field_done  = 1'b0;
            end
            if (reg_wdata[`MGR_CT_START_TEMP]) begin
                next_s.start_temp = 1'b1;
                next_s.temp_done  = 1'b0;
            end
            if (reg_wdata[`MGR_CT_SET_PULSE]) begin
                next_s.set_req = 1'b1;
            end
            if (reg_wdata[`MGR_CT_RESET_PULSE]) begin
                next_s.reset_req = 1'b1;
            end
            if (reg_wdata[`MGR_CT_OTP_RELOAD]) begin
                next_s.otp_req = 1'b1;
            end
        end

        // sequencer
        case (s.seq)
            mgr_pkg::MGR_IDLE: begin
                // field first if the host breaks the one-at-a-time contract
                if (s.start_field) begin
                    if (s.auto_en) begin
                        next_s.go_set = 1'b1;
                        next_s.seq    = mgr_pkg::MGR_COIL_AUTO;
                    end else begin
                        next_s.afe_field_start = 1'b1;
                        next_s.seq             = mgr_pkg::MGR_FIELD;
                    end
                end else if (s.start_temp) begin
                    next_s.afe_temp_start = 1'b1;
                    next_s.seq            = mgr_pkg::MGR_TEMP;
                end else if (s.set_req) begin
                    next_s.go_set    = 1'b1;
                    next_s.fired_set = 1'b1;
                    next_s.seq       = mgr_pkg::MGR_COIL_MAN;
                end else if (s.reset_req) begin
                    next_s.go_reset  = 1'b1;
                    next_s.fired_set = 1'b0;
                    next_s.seq       = mgr_pkg::MGR_COIL_MAN;
                end else if (s.otp_req) begin
                    next_s.otp_start = 1'b1;
                    next_s.seq       = mgr_pkg::MGR_OTP;
                end
            end
            mgr_pkg::MGR_COIL_MAN: begin
                if (pulse_done) begin
                    if (s.fired_set) begin
                        next_s.set_req = 1'b0;
                    end else begin
                        next_s.reset_req = 1'b0;
                    end
                    next_s.seq = mgr_pkg::MGR_IDLE;
                end
            end
            mgr_pkg::MGR_COIL_AUTO: begin
                if (pulse_done) begin
                    next_s.afe_field_start = 1'b1;
                    next_s.seq             = mgr_pkg::MGR_FIELD;
                end
            end
            mgr_pkg::MGR_FIELD: begin
                if (afe_field_done) begin
                    // one capture for all axes keeps a sample consistent
                    next_s.x           = afe_x;
                    next_s.y           = afe_y;
                    next_s.z           = afe_z;
                    next_s.field_done  = 1'b1;
                    next_s.field_pend  = 1'b1;
                    next_s.start_field = 1'b0;
                    next_s.seq         = mgr_pkg::MGR_IDLE;
                end
            end
            mgr_pkg::MGR_TEMP: begin
                if (afe_temp_done) begin
                    next_s.temp       = afe_temp;
                    next_s.temp_done  = 1'b1;
                    next_s.temp_pend  = 1'b1;
                    next_s.start_temp = 1'b0;
                    next_s.seq        = mgr_pkg::MGR_IDLE;
                end
            end
            mgr_pkg::MGR_OTP: begin
                if (otp_done) begin
                    next_s.otp_done = otp_ok;
                    next_s.otp_req  = 1'b0;
                    next_s.seq      = mgr_pkg::MGR_IDLE;
                end
            end
            default: begin
                next_s.seq = mgr_pkg::MGR_IDLE;
            end
        endcase

        // read answer one cycle after the strobe; the block never starts a transfer
        if (reg_read) begin
            next_s.rvalid = 1'b1;
            if (reg_addr == `MGR_ADDR_X_HIGH) begin
                next_s.rdata = s.x[17:10];
            end else if (reg_addr == `MGR_ADDR_X_MID) begin
                next_s.rdata = s.x[9:2];
            end else if (reg_addr == `MGR_ADDR_Y_HIGH) begin
                next_s.rdata = s.y[17:10];
            end else if (reg_addr == `MGR_ADDR_Y_MID) begin
                next_s.rdata = s.y[9:2];
            end else if (reg_addr == `MGR_ADDR_Z_HIGH) begin
                next_s.rdata = s.z[17:10];
            end else if (reg_addr == `MGR_ADDR_Z_MID) begin
                next_s.rdata = s.z[9:2];
            end else if (reg_addr == `MGR_ADDR_LOW_BITS) begin
                next_s.rdata = {s.x[1:0], s.y[1:0], s.z[1:0], `MGR_LOW_PAD};
            end else if (reg_addr == `MGR_ADDR_TEMP) begin
                next_s.rdata = s.temp;
            end else if (reg_addr == `MGR_ADDR_STATUS) begin
                next_s.rdata                     = `MGR_BYTE_ZERO;
                next_s.rdata[`MGR_ST_FIELD_DONE] = s.field_done;
                next_s.rdata[`MGR_ST_TEMP_DONE]  = s.temp_done;
                next_s.rdata[`MGR_ST_OTP_DONE]   = s.otp_done;
            end else begin
                // control is write only; unmapped reads answer zero
                next_s.rdata = `MGR_BYTE_ZERO;
            end
        end

        // interrupt pin: level while a pending flag stands and the enable is set
        next_s.int_out = next_s.int_en && (next_s.field_pend || next_s.temp_pend);
        next_s.int_oe  = next_s.int_en;
    end

    // state register, frozen while the enable is low
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register
    assign reg_rdata       = s.rdata;
    assign reg_rvalid      = s.rvalid;
    assign afe_field_start = s.afe_field_start;
    assign afe_temp_start  = s.afe_temp_start;
    assign otp_start       = s.otp_start;
    assign int_out         = s.int_out;
    assign int_oe          = s.int_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_axis_capture: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && field_end) |=> (s.field_done && s.x == $past(afe_x)
            && s.y == $past(afe_y) && s.z == $past(afe_z) && !s.start_field))
        else $error("axis capture or flag wrong at field end");

    a_field_clear: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && wr_ctrl && reg_wdata[`MGR_CT_START_FIELD] && !field_end)
            |=> !s.field_done)
        else $error("field done not cleared by command");

    a_temp_end: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && temp_end) |=> (s.temp_done && !s.start_temp && s.temp == $past(afe_temp)))
        else $error("temperature end handling wrong");

    a_irq_clear: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && wr_status && reg_wdata[`MGR_ST_FIELD_DONE] && !field_end)
            |=> (!s.field_pend && s.field_done == $past(s.field_done)))
        else $error("interrupt clear wrong");

    a_int_level: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && s.int_en && s.field_pend && !wr_status && !wr_ctrl) |=> int_out)
        else $error("interrupt dropped while pending");

    a_int_hiz: assert property (@(posedge clock) disable iff (!rst_b)
        !int_oe |-> !int_out)
        else $error("interrupt pin driven while disabled");

    a_int_enable: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && wr_ctrl) |=> (int_oe == $past(reg_wdata[`MGR_CT_INT_EN])))
        else $error("interrupt pin enable does not follow control write");

    a_auto_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && s.seq == mgr_pkg::MGR_IDLE && s.start_field && s.auto_en)
            |=> (s.go_set && s.seq == mgr_pkg::MGR_COIL_AUTO))
        else $error("auto pulse not issued");

    a_otp_done: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && s.seq == mgr_pkg::MGR_OTP && otp_done)
            |=> (s.otp_done == $past(otp_ok) && !s.otp_req))
        else $error("trim load status wrong");

    a_read_answer: assert property (@(posedge clock) disable iff (!rst_b)
        clk_en |=> (s.rvalid == $past(reg_read)))
        else $error("answer without request");

endmodule

// [verif/mgr_front_model.sv]
// front end and trim memory stand-in answering the sequencer's start pulses
`timescale 1ns/100ps
`include "mgr_params.svh"

module mgr_front_model #(
    parameter int                     LAT = 12,
    parameter logic [`MGR_AXIS_W-1:0] VX  = 18'h2_a5c3,
    parameter logic [`MGR_AXIS_W-1:0] VY  = 18'h1_3c69,
    parameter logic [`MGR_AXIS_W-1:0] VZ  = 18'h3_0f0e,
    parameter logic [`MGR_TEMP_W-1:0] VT  = 8'h5a
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   field_start,
    input  wire logic                   temp_start,
    input  wire logic                   trim_start,
    output logic                        field_done,
    output logic                        temp_done,
    output logic                        trim_done,
    output logic                        trim_ok,
    output logic [`MGR_AXIS_W-1:0]      afe_x,
    output logic [`MGR_AXIS_W-1:0]      afe_y,
    output logic [`MGR_AXIS_W-1:0]      afe_z,
    output logic [`MGR_TEMP_W-1:0]      afe_temp
);
    logic [7:0] cnt;
    logic [1:0] kind;
    logic       ok_next;
    logic       live;

    ////////////////////////////////////////////////////////////////////////////////
    // one job at a time, fixed latency then a one-cycle done pulse
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt     <= 8'h00;
            kind    <= 2'h0;
            ok_next <= 1'b1;
        end else if (field_start || temp_start || trim_start) begin
            cnt  <= LAT[7:0];
            kind <= field_start ? 2'h1 : (temp_start ? 2'h2 : 2'h3);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            // trim load alternates good and bad so both outcomes get seen
            if (cnt == 8'h01 && kind == 2'h3) begin
                ok_next <= !ok_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data only valid with its done pulse; inverted otherwise so a late capture shows
    assign live       = (cnt == 8'h01);
    assign field_done = live && kind == 2'h1;
    assign temp_done  = live && kind == 2'h2;
    assign trim_done  = live && kind == 2'h3;
    assign trim_ok    = trim_done ? ok_next : !ok_next;
    assign afe_x      = field_done ? VX : ~VX;
    assign afe_y      = field_done ? VY : ~VY;
    assign afe_z      = field_done ? VZ : ~VZ;
    assign afe_temp   = temp_done ? VT : ~VT;
endmodule

// [verif/mgr_top_tb.sv]
// self-checking bench for the magnetometer readout and control block
`timescale 1ns/100ps
`include "mgr_params.svh"

module mgr_top_tb;
    localparam logic [17:0] VX = 18'h2_a5c3;
    localparam logic [17:0] VY = 18'h1_3c69;
    localparam logic [17:0] VZ = 18'h3_0f0e;
    localparam logic [7:0]  VT = 8'h5a;
    logic        clock, rst_b, clk_en, reg_write, reg_read, reg_rvalid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, afe_temp;
    logic        fstart, fdone, tstart, tdone, ostart, odone, ook;
    logic        coil_set, coil_reset, int_out, int_oe;
    logic [17:0] afe_x, afe_y, afe_z;
    int          miscompares, n_compared, n;

    mgr_top mgr_top_inst (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .afe_field_start(fstart), .afe_field_done(fdone), .afe_x(afe_x),
        .afe_y(afe_y), .afe_z(afe_z), .afe_temp_start(tstart),
        .afe_temp_done(tdone), .afe_temp(afe_temp), .otp_start(ostart),
        .otp_done(odone), .otp_ok(ook), .coil_set(coil_set),
        .coil_reset(coil_reset), .int_out(int_out), .int_oe(int_oe));
    mgr_front_model #(.VX(VX), .VY(VY), .VZ(VZ), .VT(VT)) mgr_front_model_inst (
        .clock(clock), .rst_b(rst_b), .field_start(fstart), .temp_start(tstart),
        .trim_start(ostart), .field_done(fdone), .temp_done(tdone),
        .trim_done(odone), .trim_ok(ook), .afe_x(afe_x), .afe_y(afe_y),
        .afe_z(afe_z), .afe_temp(afe_temp));

    ////////////////////////////////////////////////////////////////////////////////
    // shared compare, verdict and register port tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // strobes are one-cycle pulses launched at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk({24'h0, reg_rdata}, {24'h0, e});
    endtask
    // bounded wait: a missing interrupt ends the run
    task automatic wait_int();
        for (int i = 0; i < 400 && int_out !== 1'b1; i++) @(negedge clock);
        if (int_out !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask
    task automatic count_coil(input bit rst_side);
        n = 0;
        repeat (90) begin
            @(negedge clock);
            n += rst_side ? int'(coil_reset === 1'b1) : int'(coil_set === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        for (int a = 0; a < 11; a++) rd(a[7:0], 8'h00);
        chk({31'h0, int_oe}, 32'h0);
    endtask
    task automatic t_field();
        wr(8'h09, 8'h05);
        rd(8'h08, 8'h00);
        wait_int();
        rd(8'h08, 8'h01);
        rd(8'h00, VX[17:10]);
        rd(8'h01, VX[9:2]);
        rd(8'h02, VY[17:10]);
        rd(8'h03, VY[9:2]);
        rd(8'h04, VZ[17:10]);
        rd(8'h05, VZ[9:2]);
        rd(8'h06, {VX[1:0], VY[1:0], VZ[1:0], 2'h0});
        chk({31'h0, int_oe}, 32'h1);
        wr(8'h08, 8'h00);
        chk({31'h0, int_out}, 32'h1);
        wr(8'h08, 8'h01);
        chk({31'h0, int_out}, 32'h0);
        rd(8'h08, 8'h01);
    endtask
    task automatic t_temp();
        wr(8'h09, 8'h06);
        rd(8'h08, 8'h01);
        wait_int();
        rd(8'h07, VT);
        rd(8'h08, 8'h03);
        wr(8'h08, 8'h02);
        chk({31'h0, int_out}, 32'h0);
    endtask
    task automatic t_coil();
        wr(8'h09, 8'h08);
        chk({31'h0, int_oe}, 32'h0);
        count_coil(1'b0);
        chk(n, 50);
        wr(8'h09, 8'h10);
        count_coil(1'b1);
        chk(n, 50);
        wr(8'h09, 8'h21);
        count_coil(1'b0);
        chk(n, 50);
        repeat (20) @(negedge clock);
        rd(8'h08, 8'h03);
        chk({31'h0, int_out}, 32'h0);
    endtask
    task automatic t_trim();
        clk_en = 1'b0;
        wr(8'h09, 8'h04);
        clk_en = 1'b1;
        chk({31'h0, int_oe}, 32'h0);
        wr(8'h09, 8'h40);
        repeat (30) @(negedge clock);
        rd(8'h08, 8'h13);
        wr(8'h09, 8'h40);
        repeat (30) @(negedge clock);
        rd(8'h08, 8'h03);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200us;
        miscompares++;
        give_verdict();
    end
    initial begin
        miscompares = 0;
        n_compared = 0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        t_field();
        t_temp();
        t_coil();
        t_trim();
        give_verdict();
    end
endmodule
